//--- verilog/apt_top.v
// transmit framing engine of the first audio serial port with its register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "apt_regs.vh"
module apt_top (
    // clock, reset, enable
    input wire REF_CLK,
    input wire RST,
    input wire CE,
    // axi4-lite register bus
    input wire [`APT_ADDR_W-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output wire [1:0] S_AXI_BRESP,
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [`APT_ADDR_W-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // adc sample side
    input wire [23:0] ADC_LEFT,
    input wire [23:0] ADC_RIGHT,
    output reg ADC_TAKE,
    // received words
    output reg [31:0] RX_LEFT,
    output reg [31:0] RX_RIGHT,
    output reg RX_VALID,
    // serial link pins
    input wire PORT_BIT_CLOCK_I,
    output reg PORT_BIT_CLOCK_O,
    output reg PORT_BIT_CLOCK_OE_N,
    input wire PORT_FRAME_CLOCK_I,
    output reg PORT_FRAME_CLOCK_O,
    output reg PORT_FRAME_CLOCK_OE_N,
    output reg PORT_TX_DATA_O,
    output reg PORT_TX_DATA_OE_N,
    input wire PORT_RX_DATA_I
);
    wire [15:0] tx_fmt;
    wire [15:0] port_ctrl;
    reg [15:0] act_fmt_ff;
    reg [2:0] act_ctrl_ff;
    reg frame_tgl_ff;

    apt_axil u_regs (
        .clk(REF_CLK), .rst(RST), .ce(CE),
        .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID), .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA), .wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY), .bresp(S_AXI_BRESP), .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY), .araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA), .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY),
        .tx_fmt(tx_fmt), .port_ctrl(port_ctrl),
        .status({act_fmt_ff[15:1], frame_tgl_ff})
    );

    // live controls; the rest is taken at frame start
    wire master = port_ctrl[`APT_BIT_MSTR];
    wire loop = port_ctrl[`APT_BIT_LOOP];
    wire binv = tx_fmt[`APT_BIT_BINV];
    wire tdm = tx_fmt[`APT_BIT_TDM];
    wire slot = tx_fmt[`APT_BIT_SLOT];
    wire [1:0] fmt = act_fmt_ff[`APT_FMT_HI:`APT_FMT_LO];
    wire [1:0] new_fmt = tx_fmt[`APT_FMT_HI:`APT_FMT_LO];
    wire dsp = (fmt == `APT_FMT_DSP);
    wire mono = act_ctrl_ff[2] & dsp;
    wire comp = act_ctrl_ff[1];
    wire alaw = act_ctrl_ff[0];

    // 8-bit words exist only through companding
    function [5:0] wl_bits;
        input [1:0] code;
        input c;
        begin
            if (c)
                wl_bits = 6'd8;
            else
                case (code)
                    2'h0: wl_bits = 6'd16;
                    2'h1: wl_bits = 6'd20;
                    2'h2: wl_bits = 6'd24;
                    default: wl_bits = 6'd32;
                endcase
        end
    endfunction

    // period -> {in word, word index, bit in word}
    function [8:0] locate;
        input [8:0] p;
        input [8:0] off;
        input [5:0] wl;
        reg [8:0] r;
        reg [8:0] w;
        begin
            locate = 9'h0;
            w = {3'h0, wl};
            r = p - off;
            if (p >= off) begin
                if (r < w)
                    locate = {3'b100, r[5:0]};
                else if (r < (w << 1))
                    locate = {3'b101, r[5:0] - w[5:0]};
                else if (r < (w << 1) + w)
                    locate = {3'b110, r[5:0] - w[5:0] - w[5:0]};
                else if (r < (w << 2))
                    locate = {3'b111, r[5:0] - w[5:0] - w[5:0] - w[5:0]};
            end
        end
    endfunction

    // g.711 style 8-bit code from the left-aligned sample
    function [7:0] compand;
        input [31:0] smp;
        input a;
        reg sgn;
        reg [15:0] m;
        reg [12:0] mag;
        reg [2:0] ex;
        reg [3:0] mt;
        integer i;
        begin
            sgn = smp[31];
            m = sgn ? ~smp[31:16] : smp[31:16];
            ex = 3'h0;
            if (a) begin
                mag = {1'b0, m[14:3]};
                for (i = 5; i < 12; i = i + 1)
                    if (mag[i]) ex = i[2:0] - 3'h4;
                mt = (ex == 3'h0) ? mag[4:1] : mag[ex +: 4];
                compand = {1'b0, ex, mt} ^ (sgn ? 8'h55 : 8'hd5);
            end else begin
                mag = (m[14:2] > 13'h1fde) ? 13'h1fde : m[14:2];
                mag = mag + 13'h0021;
                for (i = 5; i < 13; i = i + 1)
                    if (mag[i]) ex = i[2:0] - 3'h5;
                mt = mag[({1'b0, ex} + 4'h1) +: 4];
                compand = {1'b0, ex, mt} ^ (sgn ? 8'h7f : 8'hff);
            end
        end
    endfunction

    // pin synchronisers and master clock generator
    reg bs1_ff, bs2_ff, fs1_ff, fs2_ff, rs1_ff, rs2_ff;
    reg [7:0] mdiv_ff;
    reg ib_ff;
    reg [5:0] mbit_ff;
    reg mlrc_ff;
    wire [5:0] mbit_nx = mbit_ff + 6'h1;
    reg eff_prev_ff;
    reg lrc_prev_ff;
    reg [8:0] cnt_ff;
    reg [8:0] half_len_ff;
    reg left_half_ff;
    reg drv_ff;
    reg [23:0] adc_l_ff, adc_r_ff;
    reg [31:0] rx_sh_ff;

    wire eff = master ? ib_ff : (bs2_ff ^ binv);
    wire rise = eff & ~eff_prev_ff;
    wire fall = ~eff & eff_prev_ff;
    wire lrc = master ? mlrc_ff : fs2_ff;
    wire chg = lrc ^ lrc_prev_ff;
    wire half_start = dsp ? (chg & lrc) : chg;
    wire frame_start = (fmt == `APT_FMT_I2S) ? (chg & ~lrc) : (chg & lrc);
    wire [5:0] wl = wl_bits(act_fmt_ff[`APT_WL_HI:`APT_WL_LO], comp);
    wire [8:0] rj_off = (half_len_ff >= {3'h0, wl}) ? half_len_ff - {3'h0, wl} : 9'h0;
    wire [8:0] off = (fmt == `APT_FMT_RJ) ? rj_off :
                     (fmt == `APT_FMT_LJ) ? 9'h0 : 9'h1;
    wire [8:0] loc = locate(cnt_ff, off, wl);
    wire [1:0] wi = loc[7:6];
    wire [5:0] bw = loc[5:0];
    wire chan_r = dsp ? wi[0] : ~left_half_ff;
    wire in_slot = tdm ? (dsp ? (wi[1] == slot) : (wi[0] == slot))
                       : (dsp ? ~wi[1] : (wi == 2'h0));
    wire ours = loc[8] & in_slot & ~(mono & chan_r);
    wire sel_r = chan_r ? act_fmt_ff[`APT_BIT_RSRC] : act_fmt_ff[`APT_BIT_LSRC];
    wire [31:0] lin = {sel_r ? adc_r_ff : adc_l_ff, 8'h0};
    wire [31:0] word = comp ? {compand(lin, alaw), 24'h0} : lin;
    wire [4:0] msb_pos = 5'h1f - bw[4:0];
    wire rx_bit = loop ? PORT_TX_DATA_O : rs2_ff;
    wire [31:0] rx_next = {rx_sh_ff[30:0], rx_bit};
    wire [5:0] rx_pad = 6'd32 - wl;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bs1_ff <= 1'b0;
            bs2_ff <= 1'b0;
            fs1_ff <= 1'b0;
            fs2_ff <= 1'b0;
            rs1_ff <= 1'b0;
            rs2_ff <= 1'b0;
            mdiv_ff <= 8'h0;
            ib_ff <= 1'b0;
            mbit_ff <= 6'h0;
            mlrc_ff <= 1'b0;
            PORT_BIT_CLOCK_O <= 1'b0;
            PORT_BIT_CLOCK_OE_N <= 1'b1;
            PORT_FRAME_CLOCK_O <= 1'b0;
            PORT_FRAME_CLOCK_OE_N <= 1'b1;
        end else if (CE) begin
            bs1_ff <= PORT_BIT_CLOCK_I;
            bs2_ff <= bs1_ff;
            fs1_ff <= PORT_FRAME_CLOCK_I;
            fs2_ff <= fs1_ff;
            rs1_ff <= PORT_RX_DATA_I;
            rs2_ff <= rs1_ff;
            PORT_BIT_CLOCK_OE_N <= ~master;
            PORT_FRAME_CLOCK_OE_N <= ~master;
            PORT_BIT_CLOCK_O <= ib_ff ^ binv;
            PORT_FRAME_CLOCK_O <= mlrc_ff;
            if (mdiv_ff == `APT_MBCLK_HALF - 1) begin
                mdiv_ff <= 8'h0;
                ib_ff <= ~ib_ff;
                // frame clock moves with the falling bit clock, 64 bits a frame
                if (ib_ff) begin
                    mbit_ff <= mbit_nx;
                    case (new_fmt)
                        `APT_FMT_I2S: mlrc_ff <= mbit_nx >= `APT_MASTER_HALF_BITS;
                        `APT_FMT_DSP: mlrc_ff <= mbit_nx == 6'h0;
                        default: mlrc_ff <= mbit_nx < `APT_MASTER_HALF_BITS;
                    endcase
                end
            end else begin
                mdiv_ff <= mdiv_ff + 8'h1;
            end
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            eff_prev_ff <= 1'b0;
            lrc_prev_ff <= 1'b0;
            cnt_ff <= 9'h0;
            half_len_ff <= 9'h0;
            left_half_ff <= 1'b1;
            drv_ff <= 1'b0;
            act_fmt_ff <= `APT_TX_FMT_RESET;
            act_ctrl_ff <= 3'h0;
            adc_l_ff <= 24'h0;
            adc_r_ff <= 24'h0;
            frame_tgl_ff <= 1'b0;
            ADC_TAKE <= 1'b0;
            PORT_TX_DATA_O <= 1'b0;
            PORT_TX_DATA_OE_N <= 1'b0;
            rx_sh_ff <= 32'h0;
            RX_LEFT <= 32'h0;
            RX_RIGHT <= 32'h0;
            RX_VALID <= 1'b0;
        end else if (CE) begin
            eff_prev_ff <= eff;
            lrc_prev_ff <= lrc;
            ADC_TAKE <= 1'b0;
            RX_VALID <= 1'b0;
            drv_ff <= 1'b0;
            // frame edge wins over a bit clock fall seen in the same cycle
            if (half_start) begin
                cnt_ff <= 9'h0;
                half_len_ff <= cnt_ff + 9'h1;
                left_half_ff <= dsp | ((fmt == `APT_FMT_I2S) ? ~lrc : lrc);
                drv_ff <= 1'b1;
            end else if (fall) begin
                cnt_ff <= (cnt_ff == 9'h1ff) ? cnt_ff : cnt_ff + 9'h1;
                drv_ff <= 1'b1;
            end
            if (frame_start) begin
                act_fmt_ff <= tx_fmt;
                act_ctrl_ff <= {port_ctrl[`APT_BIT_MONO], port_ctrl[`APT_BIT_COMP],
                                port_ctrl[`APT_BIT_ALAW]};
                adc_l_ff <= ADC_LEFT;
                adc_r_ff <= ADC_RIGHT;
                ADC_TAKE <= 1'b1;
                frame_tgl_ff <= ~frame_tgl_ff;
            end
            // drive one cycle after the event so the new frame settings apply
            if (drv_ff) begin
                PORT_TX_DATA_O <= ours & word[msb_pos];
                PORT_TX_DATA_OE_N <= tdm & ~ours;
            end
            if (rise & ours) begin
                rx_sh_ff <= rx_next;
                if (bw == wl - 6'h1) begin
                    RX_VALID <= 1'b1;
                    if (chan_r)
                        RX_RIGHT <= rx_next << rx_pad;
                    else
                        RX_LEFT <= rx_next << rx_pad;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/apt_regs.vh
// register map, field positions, reset values and timing counts of the audio port
// What this block does
// - left slot source: 0 left, 1 right
// - right slot source: 0 left, 1 right
// - tdm enable on transmit data line
// - tdm slot choice: slot 0 or 1
// - bit clock invert, master and slave
// - word length 16/20/24/32, reset 24
// - 8-bit samples only through companding controls
// - framing: right, left, i2s, dsp
// - mono only allowed in dsp framing
// - master generates clocks, slave accepts them
// - loopback feeds transmit data into receive
`ifndef APT_REGS_VH
`define APT_REGS_VH
`define APT_ADDR_W 12
`define APT_OFS_TX_FMT 12'h300
`define APT_OFS_PORT_CTRL 12'h304
`define APT_OFS_STATUS 12'h308
`define APT_TX_FMT_RESET 16'h4050
`define APT_PORT_CTRL_RESET 16'h0000
`define APT_BIT_LSRC 15
`define APT_BIT_RSRC 14
`define APT_BIT_TDM 13
`define APT_BIT_SLOT 12
`define APT_BIT_BINV 8
`define APT_WL_HI 6
`define APT_WL_LO 5
`define APT_FMT_HI 4
`define APT_FMT_LO 3
`define APT_BIT_MSTR 14
`define APT_BIT_MONO 8
`define APT_BIT_COMP 2
`define APT_BIT_ALAW 1
`define APT_BIT_LOOP 0
`define APT_FMT_RJ 2'h0
`define APT_FMT_LJ 2'h1
`define APT_FMT_I2S 2'h2
`define APT_FMT_DSP 2'h3
`define APT_RESP_OKAY 2'h0
`define APT_RESP_SLVERR 2'h2
// master bit clock: 80 ns period from a 5 ns reference
`define APT_REF_PERIOD_NS 5
`define APT_MBCLK_PERIOD_NS 80
`define APT_MBCLK_HALF (`APT_MBCLK_PERIOD_NS / (2 * `APT_REF_PERIOD_NS))
`define APT_MASTER_HALF_BITS 32
`endif

//--- verilog/apt_axil.v
// axi4-lite slave holding the audio port control registers
`timescale 1ns/1ps
`default_nettype none
`include "apt_regs.vh"
module apt_axil (
    // clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // write channels
    input wire [`APT_ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // read channels
    input wire [`APT_ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // register contents
    output reg [15:0] tx_fmt,
    output reg [15:0] port_ctrl,
    input wire [15:0] status
);
    reg aw_got_ff;
    reg w_got_ff;
    reg [`APT_ADDR_W-1:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;

    // byte lanes 0 and 1 only; upper lanes hold no bits
    function [15:0] merge;
        input [15:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `APT_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `APT_RESP_OKAY;
            rdata <= 32'h0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= {`APT_ADDR_W{1'b0}};
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            tx_fmt <= `APT_TX_FMT_RESET;
            port_ctrl <= `APT_PORT_CTRL_RESET;
        end else if (ce) begin
            // one-cycle ready pulses keep the ready outputs registered
            awready <= awvalid & ~awready & ~aw_got_ff & ~bvalid;
            wready <= wvalid & ~wready & ~w_got_ff & ~bvalid;
            if (awvalid & awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= awaddr;
            end
            if (wvalid & wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
            end
            if (aw_got_ff & w_got_ff & ~bvalid) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `APT_RESP_OKAY;
                case (aw_addr_ff)
                    `APT_OFS_TX_FMT: tx_fmt <= merge(tx_fmt, w_data_ff, w_strb_ff);
                    `APT_OFS_PORT_CTRL: port_ctrl <= merge(port_ctrl, w_data_ff, w_strb_ff);
                    `APT_OFS_STATUS: bresp <= `APT_RESP_OKAY;
                    default: bresp <= `APT_RESP_SLVERR;
                endcase
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
            arready <= arvalid & ~arready & ~rvalid;
            if (arvalid & arready) begin
                rvalid <= 1'b1;
                rresp <= `APT_RESP_OKAY;
                case (araddr)
                    `APT_OFS_TX_FMT: rdata <= {16'h0, tx_fmt};
                    `APT_OFS_PORT_CTRL: rdata <= {16'h0, port_ctrl};
                    `APT_OFS_STATUS: rdata <= {16'h0, status};
                    default: begin
                        rdata <= 32'h0;
                        rresp <= `APT_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/apt_sva.sv
// concurrent checks on the audio port top level
`timescale 1ns/1ps
`default_nettype none
module apt_sva (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // register bus
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // sample and link side
    input wire logic ADC_TAKE,
    input wire logic PORT_BIT_CLOCK_O,
    input wire logic PORT_BIT_CLOCK_OE_N,
    input wire logic PORT_FRAME_CLOCK_O,
    input wire logic PORT_FRAME_CLOCK_OE_N
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    a_awready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("write address ready longer than one cycle");
    a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID) else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
        else $error("read data late");
    a_no_aw_in_b: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("address taken while response pending");
    a_take_pulse: assert property (ADC_TAKE |=> !ADC_TAKE [*8])
        else $error("sample take repeated within a frame");
    a_master_half: assert property (@(posedge REF_CLK) disable iff (RST || PORT_BIT_CLOCK_OE_N)
        $changed(PORT_BIT_CLOCK_O) |=> $stable(PORT_BIT_CLOCK_O) [*7] ##1
        $changed(PORT_BIT_CLOCK_O)) else $error("master bit clock half period wrong");
    a_clock_oe_pair: assert property (PORT_BIT_CLOCK_OE_N == PORT_FRAME_CLOCK_OE_N)
        else $error("bit and frame clock drive differ");
    a_frame_on_bit: assert property (disable iff (RST || PORT_FRAME_CLOCK_OE_N)
        $changed(PORT_FRAME_CLOCK_O) |-> $changed(PORT_BIT_CLOCK_O))
        else $error("master frame clock moved off a bit clock edge");

    cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
    cover property (ADC_TAKE);
    cover property (!PORT_BIT_CLOCK_OE_N);
endmodule
bind apt_top apt_sva chk_u (.REF_CLK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .ADC_TAKE,
    .PORT_BIT_CLOCK_O, .PORT_BIT_CLOCK_OE_N, .PORT_FRAME_CLOCK_OE_N, .PORT_FRAME_CLOCK_O);
`default_nettype wire

//--- verif/apt_link_model.sv
// far-end audio device: makes bit and frame clocks, captures the transmit line
`timescale 1ns/1ps
`default_nettype none
module apt_link_model (
    // clocks and data toward the port
    output logic bit_clock,
    output logic frame_clock,
    output logic rx_data,
    // transmit line from the port
    input wire logic tx_line
);
    logic [63:0] cap_ff;
    logic ebit_ff;
    logic inv_ff;
    assign bit_clock = ebit_ff ^ inv_ff;
    initial begin
        ebit_ff = 1'b0;
        inv_ff = 1'b0;
        frame_clock = 1'b1;
        rx_data = 1'b0;
        cap_ff = '0;
    end
    // left half level per framing; dsp gives a one-bit pulse
    function automatic logic fc_level(input logic [1:0] fmt, input int i);
        if (fmt == 2'h3) return i == 0;
        return (i < 32) ^ (fmt == 2'h2);
    endfunction
    // clock stands still between bursts, as a real far end may do
    task automatic run(input int n, input logic [1:0] fmt, input logic inv);
        int k;
        int i;
        inv_ff = inv;
        for (k = 0; k < n; k++) begin
            for (i = 0; i < 64; i++) begin
                ebit_ff = 1'b0;
                frame_clock = fc_level(fmt, i);
                rx_data = i[0];
                #40;
                ebit_ff = 1'b1;
                cap_ff[63 - i] = tx_line;
                #40;
            end
        end
        ebit_ff = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/tb_audio_port_transmit_format.sv
// self-checking bench for the audio port transmit framing block
`timescale 1ns/1ps
`default_nettype none
module tb_audio_port_transmit_format;
    logic clk, rst, tgl, awv, wv, brdy, arv, rrdy;
    logic [11:0] awa, ara;
    logic [31:0] wd;
    logic [23:0] adc_l, adc_r;
    wire logic awr, wr, bv, arr, rv, take, rxv, bck_o, bck_oe_n, fck_o, fck_oe_n, tx_o;
    wire logic tx_oe_n, m_bck, m_fck, m_rx, bck_line, fck_line, tx_line;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, rx_l, rx_r;
    int errors, cmp_count;
    int take_cnt = 0;
    int rxv_cnt = 0;
    // a released line shows a changing pattern, not a kept value
    assign bck_line = bck_oe_n ? m_bck : bck_o;
    assign fck_line = fck_oe_n ? m_fck : fck_o;
    assign tx_line = tx_oe_n ? tgl : tx_o;

    apt_top dut_u (.REF_CLK(clk), .RST(rst), .CE(1'b1), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
        .ADC_LEFT(adc_l), .ADC_RIGHT(adc_r), .ADC_TAKE(take), .RX_LEFT(rx_l),
        .RX_RIGHT(rx_r), .RX_VALID(rxv), .PORT_BIT_CLOCK_I(bck_line),
        .PORT_BIT_CLOCK_O(bck_o), .PORT_BIT_CLOCK_OE_N(bck_oe_n),
        .PORT_FRAME_CLOCK_I(fck_line), .PORT_FRAME_CLOCK_O(fck_o),
        .PORT_FRAME_CLOCK_OE_N(fck_oe_n), .PORT_TX_DATA_O(tx_o),
        .PORT_TX_DATA_OE_N(tx_oe_n), .PORT_RX_DATA_I(m_rx));
    apt_link_model link_u (.bit_clock(m_bck), .frame_clock(m_fck), .rx_data(m_rx),
        .tx_line(tx_line));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) tgl <= ~tgl;
    // pulse counters: one-cycle outputs are seen at every edge they stand
    always @(posedge clk) begin
        if (take === 1'b1) take_cnt <= take_cnt + 1;
        if (rxv === 1'b1) rxv_cnt <= rxv_cnt + 1;
    end

    task automatic finish_test;
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = bresp;
        brdy <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rdata;
        r = rresp;
        rrdy <= 1'b0;
    endtask
    task automatic wr_ok(input logic [11:0] a, input logic [15:0] d);
        logic [1:0] r;
        axw(a, {16'h0, d}, r);
        chk({30'h0, r}, 32'h0);
    endtask
    // pull w bits from the captured frame, starting at bit period s
    task automatic chk_word(input int s, input int w, input logic [23:0] smp);
        logic [31:0] got;
        int j;
        got = '0;
        for (j = 0; j < w; j++) got = {got[30:0], link_u.cap_ff[63 - s - j]};
        chk(got, {smp, 8'h00} >> (32 - w));
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axr(12'h300, d, r);
        chk(d, 32'h4050);
        axr(12'h304, d, r);
        chk(d, 32'h0);
        axr(12'h30c, d, r);
        chk({30'h0, r}, 32'h2);
        axw(12'h30c, 32'h1234, r);
        chk({30'h0, r}, 32'h2);
    endtask
    // i2s and dsp stop at 24 bits: a 32-bit word overflows a 32-period half
    task automatic t_formats;
        int f, l, w, ls;
        for (f = 0; f < 4; f++) for (l = 0; l < 4; l++) begin
            if (l == 3 && f >= 2) continue;
            w = (l == 0) ? 16 : (l == 1) ? 20 : (l == 2) ? 24 : 32;
            wr_ok(12'h300, {l[0], f[0], 7'h0, l[1:0], f[1:0], 3'h0});
            link_u.run(2, f[1:0], 1'b0);
            ls = (f == 0) ? 32 - w : (f == 1) ? 0 : 1;
            chk_word(ls, w, l[0] ? adc_r : adc_l);
            chk_word((f == 3) ? ls + w : ls + 32, w, f[0] ? adc_r : adc_l);
        end
    endtask
    task automatic t_tdm;
        int s;
        for (s = 0; s < 2; s++) begin
            wr_ok(12'h300, {3'b011, s[0], 5'h0, 2'h0, 2'h1, 3'h0});
            link_u.run(2, 2'h1, 1'b0);
            chk_word(16 * s, 16, adc_l);
            chk_word(32 + 16 * s, 16, adc_r);
        end
    endtask
    task automatic t_invert;
        wr_ok(12'h300, 16'h4150);
        link_u.run(2, 2'h2, 1'b1);
        chk_word(1, 24, adc_l);
        chk_word(33, 24, adc_r);
    endtask
    task automatic t_loop;
        int n_take, n_rxv;
        wr_ok(12'h300, 16'h4050);
        wr_ok(12'h304, 16'h0001);
        n_take = take_cnt;
        n_rxv = rxv_cnt;
        link_u.run(2, 2'h2, 1'b0);
        repeat (20) @(posedge clk);
        chk(rx_l, {adc_l, 8'h00});
        chk(rx_r, {adc_r, 8'h00});
        chk(take_cnt - n_take, 32'd2);
        chk(rxv_cnt - n_rxv, 32'd4);
        wr_ok(12'h304, 16'h0000);
    endtask
    // dsp, mono, a-law: 8-bit code of the left sample, then silence
    task automatic t_compand;
        wr_ok(12'h300, 16'h4058);
        wr_ok(12'h304, 16'h0106);
        link_u.run(2, 2'h3, 1'b0);
        chk_word(1, 16, {8'h3b, 16'h0000});
        wr_ok(12'h304, 16'h0000);
    endtask
    task automatic t_master;
        wr_ok(12'h304, 16'h4000);
        repeat (600) @(posedge clk);
        chk({31'h0, bck_oe_n}, 32'h0);
        chk({31'h0, fck_oe_n}, 32'h0);
        wr_ok(12'h304, 16'h0000);
        repeat (10) @(posedge clk);
        chk({31'h0, bck_oe_n}, 32'h1);
    endtask

    initial begin
        rst = 1'b1;
        tgl = 1'b0;
        {awv, wv, brdy, arv, rrdy} = 5'h0;
        awa = 12'h0;
        ara = 12'h0;
        wd = 32'h0;
        adc_l = 24'hc3a5f1;
        adc_r = 24'h5b2d87;
        errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_formats();
        t_tdm();
        t_invert();
        t_loop();
        t_compand();
        t_master();
        finish_test();
    end
    initial begin
        #400000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
